// ===== timer16_defines.svh
// Register offsets, field positions, reset values and timing counts of the timer
`ifndef TIMER16_DEFINES_SVH
`define TIMER16_DEFINES_SVH

// Register indices of the two control registers; byte address is four times the index
`define IDX_MODE_CTRL     16'hffba
`define IDX_CC_CTRL       16'hffbc
// Register byte offsets in the 4 KiB window: low 12 bits of four times the index
`define OFF_MODE_CTRL     12'hee8
`define OFF_CC_CTRL       12'hef0
`define OFF_COUNTER       12'h000
`define OFF_CC_A          12'h004
`define OFF_CC_B          12'h008
`define OFF_AUX_CTRL      12'h00c
`define OFF_STATUS        12'h010

// Mode control fields
`define MC_OVF_BIT        0
`define MC_TOG_SEL_BIT    1
`define MC_RUN_LO_BIT     2
`define MC_RUN_HI_BIT     3

// Capture/compare control fields
`define CC_A_MODE_BIT     0
`define CC_A_TRIG_BIT     1
`define CC_B_MODE_BIT     2

// Auxiliary control fields: prescaler, edge selects, one-shot, output control
`define AX_PRESC_LSB      0
`define AX_EDGE_A_LSB     4
`define AX_EDGE_B_LSB     6
`define AX_OS_ENABLE_BIT  8
`define AX_OS_TRIG_BIT    9
`define AX_OUT_EN_BIT     10
`define AX_INV_A_BIT      11
`define AX_INV_B_BIT      12

// Reset values
`define RST_BYTE          8'h00
`define RST_WORD          16'h0000
`define RST_AUX           13'h0000

// Counter constants
`define CNT_ZERO          16'h0000
`define CNT_ONE           16'h0001
`define CNT_MAX           16'hffff

// Edge select codes
`define EDGE_FALL         2'b00
`define EDGE_RISE         2'b01
`define EDGE_BOTH         2'b11

`endif

// ===== timer16_pkg.sv
// Types shared by the timer design
package timer16_pkg;

    typedef enum logic [1:0] {
        RUN_STOP  = 2'b00,
        RUN_FREE  = 2'b01,
        RUN_CLR_A = 2'b10,
        RUN_CLR_M = 2'b11
    } run_mode_t;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_RESP
    } bus_state_t;

endpackage

// ===== timer16_capture_compare.sv
// 16-bit timer with two capture/compare registers and an AXI4-Lite slave
`timescale 1ns/1ps
`include "timer16_defines.svh"

module timer16_capture_compare (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic        i_edge_input_a,
    input  wire logic        i_edge_input_b,
    output logic             o_toggle_output,
    output logic             o_match_irq_a,
    output logic             o_match_irq_b,
    input  wire logic [11:0] i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [11:0] i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready
);

    // Software-visible state, plus the three event output flops
    logic [7:0]               mode_ctrl_ff;
    logic [7:0]               cc_ctrl_ff;
    logic [12:0]              aux_ff;
    logic [15:0]              counter_ff;
    logic [15:0]              cc_a_ff;
    logic [15:0]              cc_b_ff;
    logic                     toggle_ff;
    logic                     irq_a_ff;
    logic                     irq_b_ff;
    // Bus state
    timer16_pkg::bus_state_t  wr_state_ff;
    timer16_pkg::bus_state_t  rd_state_ff;
    logic                     aw_held_ff;
    logic                     w_held_ff;
    logic [11:0]              awaddr_ff;
    logic [31:0]              wdata_ff;
    logic [3:0]               wstrb_ff;
    logic [31:0]              rdata_ff;
    logic [1:0]               bresp_ff;
    logic [1:0]               rresp_ff;
    // Input synchronisers, edge history and count-clock divider
    logic [1:0]               sync_a_ff;
    logic [1:0]               sync_b_ff;
    logic                     prev_a_ff;
    logic                     prev_b_ff;
    logic                     armed_ff;
    logic [7:0]               div_ff;

    timer16_pkg::run_mode_t   run_mode;
    logic                     running;
    logic                     tick;
    logic                     rise_a;
    logic                     fall_a;
    logic                     rise_b;
    logic                     fall_b;
    logic                     valid_a;
    logic                     opposite_a;
    logic                     valid_b;
    logic                     a_capture;
    logic                     b_capture;
    logic                     trig_a;
    logic                     trig_b;
    logic                     match_a;
    logic                     match_b;
    logic                     clear_cnt;
    logic                     wrap;
    logic                     do_write;
    logic                     do_read;
    logic                     rd_counter;
    logic                     wr_mode;
    logic                     wr_cc_ctrl;
    logic                     wr_cc_a;
    logic                     wr_cc_b;
    logic                     wr_aux;
    logic                     os_trig;
    logic [15:0]              nxt_counter;
    logic [31:0]              nxt_rdata;
    logic                     nxt_tick;

    assign run_mode = timer16_pkg::run_mode_t'(mode_ctrl_ff[`MC_RUN_HI_BIT:`MC_RUN_LO_BIT]);
    assign running  = (run_mode != timer16_pkg::RUN_STOP);
    assign a_capture = cc_ctrl_ff[`CC_A_MODE_BIT];
    assign b_capture = cc_ctrl_ff[`CC_B_MODE_BIT];

    // Two-flop synchronisers for the pins
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            sync_a_ff <= 2'b00;
            sync_b_ff <= 2'b00;
        end else begin
            sync_a_ff <= {sync_a_ff[0], i_edge_input_a};
            sync_b_ff <= {sync_b_ff[0], i_edge_input_b};
        end
    end

    // Edge history; arming after stop suppresses a false first rising edge
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            prev_a_ff <= 1'b0;
            prev_b_ff <= 1'b0;
            armed_ff  <= 1'b0;
        end else begin
            prev_a_ff <= sync_a_ff[1];
            prev_b_ff <= sync_b_ff[1];
            armed_ff  <= running;
        end
    end

    assign rise_a = armed_ff & running & sync_a_ff[1] & ~prev_a_ff;
    assign fall_a = armed_ff & running & ~sync_a_ff[1] & prev_a_ff;
    assign rise_b = armed_ff & running & sync_b_ff[1] & ~prev_b_ff;
    assign fall_b = armed_ff & running & ~sync_b_ff[1] & prev_b_ff;

    // Edge select decode; prohibited code 10 detects nothing, except rising A edges for opposite-phase A capture
    function automatic logic edge_pick(input logic [1:0] sel, input logic r, input logic f);
        logic hit;
        hit = 1'b0;
        case (sel)
            `EDGE_FALL: hit = f;
            `EDGE_RISE: hit = r;
            `EDGE_BOTH: hit = r | f;
            default:    hit = 1'b0;
        endcase
        return hit;
    endfunction

    assign valid_a = edge_pick(aux_ff[`AX_EDGE_A_LSB +: 2], rise_a, fall_a);
    assign valid_b = edge_pick(aux_ff[`AX_EDGE_B_LSB +: 2], rise_b, fall_b);
    assign opposite_a = edge_pick(~aux_ff[`AX_EDGE_A_LSB +: 2] & 2'b01, rise_a, fall_a)
                        & (aux_ff[`AX_EDGE_A_LSB +: 2] != `EDGE_BOTH);

    // Capture triggers only count for a register in capture mode
    assign trig_a = a_capture & (cc_ctrl_ff[`CC_A_TRIG_BIT] ? opposite_a : valid_b);
    assign trig_b = b_capture & valid_a;

    // Count-clock divider: prescaler codes 0 to 3 pick 1, 2, 4 or 16 system clocks, higher codes 256
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            div_ff <= 8'h00;
        end else if (!running) begin
            div_ff <= 8'h00;
        end else begin
            div_ff <= div_ff + 8'h01;
        end
    end

    // Tick mask for a power-of-two prescale; a counter read stalls the tick
    always_comb begin
        nxt_tick = 1'b1;
        case (aux_ff[`AX_PRESC_LSB +: 3])
            3'd0:    nxt_tick = 1'b1;
            3'd1:    nxt_tick = (div_ff[0] == 1'b1);
            3'd2:    nxt_tick = (div_ff[1:0] == 2'b11);
            3'd3:    nxt_tick = (div_ff[3:0] == 4'hf);
            default: nxt_tick = (div_ff == 8'hff);
        endcase
    end
    assign tick = running & nxt_tick & ~rd_counter;

    assign wrap    = tick & (counter_ff == `CNT_MAX);
    // Match pulses when the counter steps onto the compare value; a zero compare
    // value matches on the step from 0000H to 0001H, never on a start or a clear
    assign match_a = tick & ~a_capture
                   & ((cc_a_ff == `CNT_ZERO) ? (counter_ff == `CNT_ZERO)
                                             : (counter_ff + `CNT_ONE == cc_a_ff));
    assign match_b = tick & ~b_capture
                   & ((cc_b_ff == `CNT_ZERO) ? (counter_ff == `CNT_ZERO)
                                             : (counter_ff + `CNT_ONE == cc_b_ff));
    assign os_trig = wr_aux & wdata_ff[`AX_OS_TRIG_BIT] & aux_ff[`AX_OS_ENABLE_BIT];
    // Match-clear holds the compare value for one count period, then clears
    assign clear_cnt = (run_mode == timer16_pkg::RUN_CLR_A && valid_a)
                     | (run_mode == timer16_pkg::RUN_CLR_M && tick && counter_ff == cc_a_ff)
                     | os_trig
                     | (aux_ff[`AX_OS_ENABLE_BIT] & valid_a);

    // Counter next value
    always_comb begin
        nxt_counter = counter_ff;
        if (!running || clear_cnt) begin
            nxt_counter = `CNT_ZERO;
        end else if (tick) begin
            nxt_counter = counter_ff + `CNT_ONE;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            counter_ff <= `RST_WORD;
        end else begin
            counter_ff <= nxt_counter;
        end
    end

    // Register bus decode
    assign do_write   = (wr_state_ff == timer16_pkg::BUS_IDLE) & aw_held_ff & w_held_ff;
    assign do_read    = (rd_state_ff == timer16_pkg::BUS_IDLE) & i_arvalid;
    assign rd_counter = do_read & (i_araddr == `OFF_COUNTER);
    assign wr_mode    = do_write & (awaddr_ff == `OFF_MODE_CTRL) & wstrb_ff[0];
    assign wr_cc_ctrl = do_write & (awaddr_ff == `OFF_CC_CTRL) & wstrb_ff[0];
    assign wr_cc_a    = do_write & (awaddr_ff == `OFF_CC_A);
    assign wr_cc_b    = do_write & (awaddr_ff == `OFF_CC_B);
    assign wr_aux     = do_write & (awaddr_ff == `OFF_AUX_CTRL);

    // Mode control; overflow set wins over a clear in the same cycle
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            mode_ctrl_ff <= `RST_BYTE;
        end else begin
            if (wr_mode) begin
                mode_ctrl_ff <= {4'h0, wdata_ff[3:0]};
                if (wdata_ff[`MC_RUN_HI_BIT:`MC_RUN_LO_BIT] == 2'b00) begin
                    mode_ctrl_ff[`MC_OVF_BIT] <= 1'b0;
                end
            end
            if (wrap) begin
                mode_ctrl_ff[`MC_OVF_BIT] <= 1'b1;
            end
        end
    end

    // Capture/compare control and auxiliary control
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            cc_ctrl_ff <= `RST_BYTE;
            aux_ff     <= `RST_AUX;
        end else begin
            if (wr_cc_ctrl) begin
                cc_ctrl_ff <= {5'h00, wdata_ff[2:0]};
            end
            if (wr_aux) begin
                aux_ff <= wdata_ff[12:0] & ~(13'h1 << `AX_OS_TRIG_BIT);
            end
        end
    end

    // Capture/compare registers: software write or hardware capture
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            cc_a_ff <= `RST_WORD;
            cc_b_ff <= `RST_WORD;
        end else begin
            if (trig_a) begin
                cc_a_ff <= counter_ff;
            end else if (wr_cc_a) begin
                cc_a_ff <= wdata_ff[15:0];
            end
            if (trig_b) begin
                cc_b_ff <= counter_ff;
            end else if (wr_cc_b) begin
                cc_b_ff <= wdata_ff[15:0];
            end
        end
    end

    // Interrupt pulses; opposite-phase capture uses the B edge as a plain event
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            irq_a_ff <= 1'b0;
            irq_b_ff <= 1'b0;
        end else begin
            if (a_capture && cc_ctrl_ff[`CC_A_TRIG_BIT]) begin
                irq_a_ff <= valid_b;
            end else begin
                irq_a_ff <= match_a | trig_a;
            end
            irq_b_ff <= match_b | trig_b;
        end
    end

    // Timer output toggle with enable and per-match inversion enables
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            toggle_ff <= 1'b0;
        end else if (!aux_ff[`AX_OUT_EN_BIT]) begin
            toggle_ff <= 1'b0;
        end else if ((match_a & aux_ff[`AX_INV_A_BIT]) | (match_b & aux_ff[`AX_INV_B_BIT])
                     | (mode_ctrl_ff[`MC_TOG_SEL_BIT] & valid_a)) begin
            toggle_ff <= ~toggle_ff;
        end
    end

    assign o_toggle_output = toggle_ff;
    assign o_match_irq_a   = irq_a_ff;
    assign o_match_irq_b   = irq_b_ff;

    // Write channel: hold address and data in either order
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            aw_held_ff  <= 1'b0;
            w_held_ff   <= 1'b0;
            awaddr_ff   <= 12'h000;
            wdata_ff    <= 32'h0000_0000;
            wstrb_ff    <= 4'h0;
            wr_state_ff <= timer16_pkg::BUS_IDLE;
            bresp_ff    <= 2'b00;
        end else begin
            unique case (wr_state_ff)
                timer16_pkg::BUS_IDLE: begin
                    if (i_awvalid && !aw_held_ff) begin
                        aw_held_ff <= 1'b1;
                        awaddr_ff  <= i_awaddr;
                    end
                    if (i_wvalid && !w_held_ff) begin
                        w_held_ff <= 1'b1;
                        wdata_ff  <= i_wdata;
                        wstrb_ff  <= i_wstrb;
                    end
                    if (do_write) begin
                        wr_state_ff <= timer16_pkg::BUS_RESP;
                        bresp_ff    <= (wr_mode | wr_cc_ctrl | wr_cc_a | wr_cc_b | wr_aux
                                       | awaddr_ff == `OFF_COUNTER
                                       | awaddr_ff == `OFF_STATUS) ? 2'b00 : 2'b10;
                    end
                end
                timer16_pkg::BUS_RESP: begin
                    if (i_bready) begin
                        wr_state_ff <= timer16_pkg::BUS_IDLE;
                        aw_held_ff  <= 1'b0;
                        w_held_ff   <= 1'b0;
                    end
                end
            endcase
        end
    end

    assign o_awready = (wr_state_ff == timer16_pkg::BUS_IDLE) & ~aw_held_ff;
    assign o_wready  = (wr_state_ff == timer16_pkg::BUS_IDLE) & ~w_held_ff;
    assign o_bvalid  = (wr_state_ff == timer16_pkg::BUS_RESP);
    assign o_bresp   = bresp_ff;

    // Read data mux
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        case (i_araddr)
            `OFF_MODE_CTRL: nxt_rdata = {24'h0, mode_ctrl_ff};
            `OFF_CC_CTRL:   nxt_rdata = {24'h0, cc_ctrl_ff};
            `OFF_COUNTER:   nxt_rdata = {16'h0, running ? counter_ff : `CNT_ZERO};
            `OFF_CC_A:      nxt_rdata = {16'h0, cc_a_ff};
            `OFF_CC_B:      nxt_rdata = {16'h0, cc_b_ff};
            `OFF_AUX_CTRL:  nxt_rdata = {19'h0, aux_ff};
            `OFF_STATUS:    nxt_rdata = {29'h0, toggle_ff, sync_b_ff[1], sync_a_ff[1]};
            default:        nxt_rdata = 32'h0000_0000;
        endcase
    end

    // Read channel
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rd_state_ff <= timer16_pkg::BUS_IDLE;
            rdata_ff    <= 32'h0000_0000;
            rresp_ff    <= 2'b00;
        end else begin
            unique case (rd_state_ff)
                timer16_pkg::BUS_IDLE: begin
                    if (do_read) begin
                        rd_state_ff <= timer16_pkg::BUS_RESP;
                        rdata_ff    <= nxt_rdata;
                        rresp_ff    <= (i_araddr == `OFF_MODE_CTRL || i_araddr == `OFF_CC_CTRL
                                       || i_araddr == `OFF_COUNTER || i_araddr == `OFF_CC_A
                                       || i_araddr == `OFF_CC_B || i_araddr == `OFF_AUX_CTRL
                                       || i_araddr == `OFF_STATUS) ? 2'b00 : 2'b10;
                    end
                end
                timer16_pkg::BUS_RESP: begin
                    if (i_rready) begin
                        rd_state_ff <= timer16_pkg::BUS_IDLE;
                    end
                end
            endcase
        end
    end

    assign o_arready = (rd_state_ff == timer16_pkg::BUS_IDLE);
    assign o_rvalid  = (rd_state_ff == timer16_pkg::BUS_RESP);
    assign o_rdata   = rdata_ff;
    assign o_rresp   = rresp_ff;

endmodule // timer16_capture_compare

// ===== timer16_capture_compare_monitor.sv
// Concurrent checks on the bus handshakes and event outputs of the timer
`timescale 1ns/1ps
module timer16_capture_compare_monitor (
    input wire logic        i_clk,
    input wire logic        i_reset,
    input wire logic        i_awvalid,
    input wire logic        o_awready,
    input wire logic        i_wvalid,
    input wire logic        o_wready,
    input wire logic [1:0]  o_bresp,
    input wire logic        o_bvalid,
    input wire logic        i_bready,
    input wire logic        i_arvalid,
    input wire logic        o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic        o_rvalid,
    input wire logic        i_rready,
    input wire logic        o_match_irq_a,
    input wire logic        o_match_irq_b
);
    default clocking mon_cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    // Bus answers, holds and blocking
    AST_WRITE_ANSWER: assert property (i_awvalid && o_awready && i_wvalid && o_wready
        |-> ##[1:3] o_bvalid) else $error("write response missing");
    AST_BVALID_HOLD: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped");
    AST_WRITE_BLOCK: assert property (o_bvalid |-> !o_awready && !o_wready)
        else $error("write accepted during response");
    AST_WRITE_RELEASE: assert property (o_bvalid && i_bready |=> !o_bvalid && o_awready
        && o_wready) else $error("write channel not released");
    AST_READ_ANSWER: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("read data late");
    AST_RVALID_HOLD: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped");
    AST_READ_BLOCK: assert property (o_rvalid |-> !o_arready)
        else $error("read accepted during data");
    // Match interrupt outputs A and B are single-cycle pulses
    AST_IRQ_A_PULSE: assert property (o_match_irq_a |=> !o_match_irq_a)
        else $error("event A longer than one cycle");
    AST_IRQ_B_PULSE: assert property (o_match_irq_b |=> !o_match_irq_b)
        else $error("event B longer than one cycle");

    COV_IRQ_A: cover property (o_match_irq_a);
    COV_IRQ_B: cover property (o_match_irq_b);
    COV_SLVERR: cover property (o_bvalid && o_bresp == 2'b10);
endmodule // timer16_capture_compare_monitor

bind timer16_capture_compare timer16_capture_compare_monitor u_monitor (
    .i_clk(i_clk), .i_reset(i_reset), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
    .i_bready(i_bready), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .o_match_irq_a(o_match_irq_a),
    .o_match_irq_b(o_match_irq_b));

// ===== timer16_pin_model.sv
// Model of the pulse sources on pins A and B and the load on the timer output
`timescale 1ns/1ps
module timer16_pin_model (
    input  wire logic i_clk,
    input  wire logic i_toggle_output,
    output logic      o_edge_input_a,
    output logic      o_edge_input_b,
    output int        o_toggles
);
    logic last_tog_ff = 1'b0;

    initial begin
        o_edge_input_a = 1'b0;
        o_edge_input_b = 1'b0;
    end

    // Count level changes on the timer output
    always @(posedge i_clk) begin
        if (i_toggle_output !== last_tog_ff) o_toggles <= o_toggles + 1;
        last_tog_ff <= i_toggle_output;
    end

    // One high then low pulse, four clocks at each level, on pin B when on_b is set, else on pin A
    task automatic pulse(input bit on_b);
        @(posedge i_clk);
        if (on_b) o_edge_input_b <= 1'b1;
        else o_edge_input_a <= 1'b1;
        repeat (4) @(posedge i_clk);
        if (on_b) o_edge_input_b <= 1'b0;
        else o_edge_input_a <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask
endmodule // timer16_pin_model

// ===== timer16_capture_compare_tb.sv
// Self-checking bench of the 16-bit capture/compare timer
`timescale 1ns/1ps
module timer16_capture_compare_tb;
    typedef struct {logic [7:0] cc; logic [12:0] aux; bit on_b; int ea; int eb;} row_t;
    logic        clk = 1'b0, reset = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic        tog, irq_a, irq_b, pin_a, pin_b;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic [1:0]  bresp, rresp, r;
    int          n_errors = 0, total_checks = 0, cyc = 0, na = 0, nb = 0, toggles, n, t0;
    row_t        rows[6] = '{
        '{8'h04, 13'h0000, 1'b0, 0, 1},
        '{8'h04, 13'h0010, 1'b0, 0, 1},
        '{8'h04, 13'h0030, 1'b0, 0, 2},
        '{8'h01, 13'h0040, 1'b1, 1, 0},
        '{8'h03, 13'h0050, 1'b0, 0, 0},
        '{8'h03, 13'h0050, 1'b1, 1, 0}};

    timer16_capture_compare dut (
        .i_clk(clk), .i_reset(reset), .i_edge_input_a(pin_a), .i_edge_input_b(pin_b),
        .o_toggle_output(tog), .o_match_irq_a(irq_a), .o_match_irq_b(irq_b),
        .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
        .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
        .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
        .i_rready(rready));
    timer16_pin_model u_pins (.i_clk(clk), .i_toggle_output(tog), .o_edge_input_a(pin_a),
        .o_edge_input_b(pin_b), .o_toggles(toggles));

    // Clock, cycle limit and event counters
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (irq_a === 1'b1) na <= na + 1;
        if (irq_b === 1'b1) nb <= nb + 1;
        if (cyc == 70000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Bus write: address and data together, held until taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", {30'h0, bresp}, {30'h0, er});
    endtask

    // Bus read, data taken at the edge that shows rvalid
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        rs = rresp;
    endtask

    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        rd(a, v, r);
        chk("rdata", v, e);
    endtask

    // Counts cycles until the chosen event pulse
    task automatic wait_irq(input bit on_b);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (((on_b ? irq_b : irq_a) !== 1'b1) && n < 300);
    endtask

    // Stop, configure, run, pulse one pin and count the events
    task automatic phase(input row_t w);
        int a0;
        int b0;
        wr(12'hee8, 32'h0, 2'b00);
        wr(12'hef0, {24'h0, w.cc}, 2'b00);
        wr(12'h004, 32'h1234, 2'b00);
        wr(12'h008, 32'hf000, 2'b00);
        wr(12'h00c, {19'h0, w.aux}, 2'b00);
        wr(12'hee8, 32'h4, 2'b00);
        a0 = na;
        b0 = nb;
        u_pins.pulse(w.on_b);
        repeat (10) @(posedge clk);
        chk("irq_a_count", na - a0, w.ea);
        chk("irq_b_count", nb - b0, w.eb);
        if (!w.cc[0]) rc(12'h004, 32'h1234);
        // A counter read leaves a captured B value alone
        if (w.cc[2]) begin
            rd(12'h008, v, r);
            t0 = v;
            rd(12'h000, v, r);
            rc(12'h008, t0);
        end
    endtask

    task automatic end_sim();
        $display("Checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        foreach (rows[i]) phase(rows[i]);
        // Both compares in free-running mode, output toggling on each match
        wr(12'hee8, 32'h0, 2'b00);
        wr(12'hef0, 32'h0, 2'b00);
        wr(12'h004, 32'h10, 2'b00);
        wr(12'h008, 32'h8, 2'b00);
        wr(12'h00c, 32'h1c00, 2'b00);
        t0 = toggles;
        wr(12'hee8, 32'h4, 2'b00);
        wait_irq(1'b1);
        wait_irq(1'b0);
        chk("match_gap", n, 8);
        repeat (3) @(posedge clk);
        chk("toggles", toggles - t0, 2);
        rd(12'h000, v, r);
        chk("counter_runs", {31'h0, v != 32'h0}, 1);
        rc(12'h008, 32'h8);
        // Clear on compare-A match, zero compare B after each clear
        wr(12'hee8, 32'h0, 2'b00);
        wr(12'h004, 32'h5, 2'b00);
        wr(12'h008, 32'h0, 2'b00);
        wr(12'hee8, 32'hc, 2'b00);
        wait_irq(1'b0);
        wait_irq(1'b0);
        chk("clear_period", n, 6);
        wait_irq(1'b1);
        chk("zero_match", n, 2);
        // Clear on a rising A edge, output also toggling on that edge
        wr(12'hee8, 32'h0, 2'b00);
        wr(12'h00c, 32'h410, 2'b00);
        wr(12'hee8, 32'ha, 2'b00);
        t0 = toggles;
        u_pins.pulse(1'b0);
        rd(12'h000, v, r);
        chk("edge_clear", v, 32'h6);
        chk("edge_toggle", toggles - t0, 1);
        // Overflow flag set, clear, stop and wrap
        wr(12'hee8, 32'h0, 2'b00);
        wr(12'hee8, 32'hd, 2'b00);
        rc(12'hee8, 32'hd);
        wr(12'hee8, 32'hc, 2'b00);
        rc(12'hee8, 32'hc);
        wr(12'hee8, 32'h1, 2'b00);
        rc(12'hee8, 32'h0);
        rc(12'h000, 32'h0);
        wr(12'hee8, 32'h4, 2'b00);
        repeat (65540) @(posedge clk);
        rc(12'hee8, 32'h5);
        // Second reset, reset values and unmapped access
        reset <= 1'b1;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        rc(12'h004, 32'h0);
        rc(12'h008, 32'h0);
        rc(12'hef0, 32'h0);
        wr(12'h100, 32'h1, 2'b10);
        rd(12'h100, v, r);
        chk("rresp", {30'h0, r}, 32'h2);
        end_sim();
    end
endmodule // timer16_capture_compare_tb
